// [rtl/lsau_params.svh]
`ifndef LSAU_PARAMS_SVH
`define LSAU_PARAMS_SVH

// =============================================================
// Address arithmetic
`define LSAU_PC_AHEAD     32'h0000_0004
`define LSAU_PC_BIT1_CLR  32'hFFFF_FFFD
`define LSAU_DUAL_STEP    32'h0000_0004
`define LSAU_BRANCH_MASK  32'hFFFF_FFFE

// =============================================================
// Immediate offset limits (magnitudes)
`define LSAU_IMM_SHORT    12'h0FF
`define LSAU_IMM_DUAL     12'h3FC
`define LSAU_IMM_ALIGN    2'h0

// =============================================================
// Byte lanes
`define LSAU_STRB_BYTE    4'h1
`define LSAU_STRB_HALF    4'h3
`define LSAU_STRB_WORD    4'hF

// =============================================================
// Reset values
`define LSAU_RST_WORD     32'h0000_0000
`define LSAU_RST_STRB     4'h0
`define LSAU_RST_FLAGS    4'h0

`endif

// [rtl/lsau_pkg.sv]
package lsau_pkg;

    // =========================================================
    // Operation, size, addressing mode and sequencer state
    typedef enum logic [2:0]
    {
        OP_ADR   = 3'b000,
        OP_LOAD  = 3'b001,
        OP_STORE = 3'b010,
        OP_LDUAL = 3'b011,
        OP_SDUAL = 3'b100
    } lsau_op_e;

    typedef enum logic [1:0]
    {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } lsau_size_e;

    typedef enum logic [1:0]
    {
        AM_OFFSET = 2'b00,
        AM_PRE    = 2'b01,
        AM_POST   = 2'b10
    } lsau_mode_e;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_MEM1 = 2'b01,
        ST_MEM2 = 2'b10
    } lsau_state_e;

    // =========================================================
    // Request from the instruction stream
    typedef struct packed
    {
        lsau_op_e    op;
        lsau_size_e  size;
        logic        sgn;
        lsau_mode_e  mode;
        logic        useReg;
        logic        sub;
        logic [11:0] imm;
        logic [1:0]  shift;
        logic        toPc;
        logic        condPass;
        logic [31:0] pcVal;
        logic [31:0] baseVal;
        logic [31:0] offVal;
        logic [31:0] store1;
        logic [31:0] store2;
    } lsau_req_s;

endpackage

// [rtl/lsau_core.sv]
// Functional notes
// - Address instruction: aligned PC plus signed immediate
// - Address instruction keeps all condition flags
// - Loads zero or sign extend bytes, halfwords
// - Missing offset: base used as address
// - Offset mode: base plus offset, no writeback
// - Pre-index: access at sum, write sum back
// - Post-index: access at base, write sum back
// - Single immediate limits: -255..4095 or +-255
// - Dual offsets: multiple of four, +-1020
// - Word load to PC branches, bit 0 cleared
// - Loads and stores keep the flags
// - Register offset shifted left zero to three
// - Register offset: byte/half/word only, no dual
// - PC base is address plus four, bit1 cleared
// - Failed condition: no write, no flags, no fault
`include "lsau_params.svh"
`timescale 1ns/1ps
`default_nettype none

module lsau_core
#(
    parameter int XLEN = 32
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Instruction stream request
    input  wire logic             reqValid,
    input  wire lsau_pkg::lsau_req_s req,
    output var  logic             reqReady_q,
    input  wire logic [3:0]       appFlagsIn,
    // Memory side
    output var  logic             memValid_q,
    output var  logic             memWrite_q,
    output var  logic [31:0]      memAddr_q,
    output var  logic [31:0]      memWdata_q,
    output var  logic [3:0]       memStrb_q,
    input  wire logic             memAck,
    input  wire logic [31:0]      memRdata,
    // Completion and writeback
    output var  logic             done_q,
    output var  logic             err_q,
    output var  logic             wbTransEn_q,
    output var  logic [31:0]      transData_q,
    output var  logic             wbSecEn_q,
    output var  logic [31:0]      secData_q,
    output var  logic             wbBaseEn_q,
    output var  logic [31:0]      baseData_q,
    output var  logic             branchEn_q,
    output var  logic [31:0]      branchAddr_q,
    output var  logic [3:0]       appFlags_q
);
    import lsau_pkg::*;

    if (XLEN != 32)
    begin : g_chk
        $error("lsau_core supports XLEN of 32 only");
    end

    // =========================================================
    // Helpers
    function automatic logic [31:0] extend(input logic [31:0] d,
                                           input logic [1:0] a,
                                           input lsau_size_e sz,
                                           input logic sg);
        logic [31:0] s;
        s = d >> {a, 3'b000};
        if (sz == SZ_BYTE)
            extend = {{24{sg & s[7]}}, s[7:0]};
        else if (sz == SZ_HALF)
            extend = {{16{sg & s[15]}}, s[15:0]};
        else
            extend = d;
    endfunction

    function automatic logic [31:0] lanes(input logic [31:0] d,
                                          input lsau_size_e sz);
        if (sz == SZ_BYTE)
            lanes = {4{d[7:0]}};
        else if (sz == SZ_HALF)
            lanes = {2{d[15:0]}};
        else
            lanes = d;
    endfunction

    function automatic logic [3:0] strobes(input logic [1:0] a,
                                           input lsau_size_e sz);
        if (sz == SZ_BYTE)
            strobes = `LSAU_STRB_BYTE << a;
        else if (sz == SZ_HALF)
            strobes = `LSAU_STRB_HALF << {a[1], 1'b0};
        else
            strobes = `LSAU_STRB_WORD;
    endfunction

    // =========================================================
    // State
    lsau_state_e state_q;
    lsau_req_s   req_q;
    logic [31:0] addr1_q;

    // =========================================================
    // Address formation
    logic [31:0] pcBase;
    logic [31:0] immExt;
    logic [31:0] offAmt;
    logic [31:0] indexed;
    logic [31:0] firstAddr;
    logic [31:0] adrVal;
    logic        isDualIn;
    logic        illegal;
    logic        noMem;
    logic        accept;

    always_comb
    begin
        pcBase  = (req.pcVal + `LSAU_PC_AHEAD) & `LSAU_PC_BIT1_CLR;
        immExt  = {20'h00000, req.imm};
        adrVal  = req.sub ? pcBase - immExt : pcBase + immExt;
        offAmt  = req.useReg ? (req.offVal << req.shift) : immExt;
        indexed = (req.sub && !req.useReg) ? req.baseVal - offAmt
                                           : req.baseVal + offAmt;
        firstAddr = (req.mode == AM_POST) ? req.baseVal : indexed;
        isDualIn  = (req.op == OP_LDUAL) || (req.op == OP_SDUAL);
    end

    always_comb
    begin
        illegal = 1'b0;
        if (req.op == OP_ADR)
            illegal = 1'b0;
        else if (req.mode != AM_OFFSET && req.mode != AM_PRE
                 && req.mode != AM_POST)
            illegal = 1'b1;
        else if (isDualIn)
            illegal = req.useReg || (req.imm > `LSAU_IMM_DUAL)
                      || (req.imm[1:0] != `LSAU_IMM_ALIGN);
        else if (req.useReg)
            illegal = req.mode != AM_OFFSET;
        else if (req.mode == AM_OFFSET)
            illegal = req.sub && (req.imm > `LSAU_IMM_SHORT);
        else
            illegal = req.imm > `LSAU_IMM_SHORT;
        if (req.op == OP_STORE && req.sgn)
            illegal = 1'b1;
    end

    assign accept = reqValid && reqReady_q && (state_q == ST_IDLE);
    assign noMem  = !req.condPass || illegal || (req.op == OP_ADR);

    // =========================================================
    // Sequencer
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q    <= ST_IDLE;
            reqReady_q <= 1'b1;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (accept && !noMem)
                    begin
                        state_q    <= ST_MEM1;
                        reqReady_q <= 1'b0;
                    end
                ST_MEM1:
                    if (memAck)
                    begin
                        if (req_q.op == OP_LDUAL || req_q.op == OP_SDUAL)
                            state_q <= ST_MEM2;
                        else
                        begin
                            state_q    <= ST_IDLE;
                            reqReady_q <= 1'b1;
                        end
                    end
                ST_MEM2:
                    if (memAck)
                    begin
                        state_q    <= ST_IDLE;
                        reqReady_q <= 1'b1;
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // =========================================================
    // Request capture
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            req_q   <= '0;
            addr1_q <= `LSAU_RST_WORD;
        end
        else if (accept)
        begin
            req_q   <= req;
            addr1_q <= firstAddr;
        end
    end

    // =========================================================
    // Memory requests
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            memValid_q <= 1'b0;
            memWrite_q <= 1'b0;
            memAddr_q  <= `LSAU_RST_WORD;
            memWdata_q <= `LSAU_RST_WORD;
            memStrb_q  <= `LSAU_RST_STRB;
        end
        else if (accept && !noMem)
        begin
            memValid_q <= 1'b1;
            memWrite_q <= (req.op == OP_STORE) || (req.op == OP_SDUAL);
            memAddr_q  <= firstAddr;
            memWdata_q <= lanes(req.store1, req.size);
            memStrb_q  <= isDualIn ? `LSAU_STRB_WORD
                                   : strobes(firstAddr[1:0], req.size);
        end
        else if (state_q == ST_MEM1 && memAck
                 && (req_q.op == OP_LDUAL || req_q.op == OP_SDUAL))
        begin
            memAddr_q  <= addr1_q + `LSAU_DUAL_STEP;
            memWdata_q <= req_q.store2;
            memStrb_q  <= `LSAU_STRB_WORD;
        end
        else if (memAck)
            memValid_q <= 1'b0;
    end

    // =========================================================
    // Completion and writeback
    logic ldWordPc;
    assign ldWordPc = (req_q.op == OP_LOAD) && (req_q.size == SZ_WORD)
                      && req_q.toPc;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            done_q       <= 1'b0;
            err_q        <= 1'b0;
            wbTransEn_q  <= 1'b0;
            wbSecEn_q    <= 1'b0;
            wbBaseEn_q   <= 1'b0;
            branchEn_q   <= 1'b0;
            transData_q  <= `LSAU_RST_WORD;
            secData_q    <= `LSAU_RST_WORD;
            baseData_q   <= `LSAU_RST_WORD;
            branchAddr_q <= `LSAU_RST_WORD;
        end
        else
        begin
            done_q      <= 1'b0;
            err_q       <= 1'b0;
            wbTransEn_q <= 1'b0;
            wbSecEn_q   <= 1'b0;
            wbBaseEn_q  <= 1'b0;
            branchEn_q  <= 1'b0;
            if (accept && noMem)
            begin
                done_q <= 1'b1;
                err_q  <= req.condPass && illegal;
                if (req.condPass && req.op == OP_ADR)
                begin
                    wbTransEn_q <= 1'b1;
                    transData_q <= adrVal;
                end
            end
            else if (accept)
                baseData_q <= indexed;
            if (state_q == ST_MEM1 && memAck)
            begin
                if (req_q.op == OP_LDUAL)
                    transData_q <= memRdata;
                else if (req_q.op == OP_LOAD && ldWordPc)
                    branchAddr_q <= memRdata & `LSAU_BRANCH_MASK;
                else if (req_q.op == OP_LOAD)
                    transData_q <= extend(memRdata, addr1_q[1:0],
                                          req_q.size, req_q.sgn);
                if (req_q.op != OP_LDUAL && req_q.op != OP_SDUAL)
                begin
                    done_q      <= 1'b1;
                    wbTransEn_q <= (req_q.op == OP_LOAD) && !ldWordPc;
                    branchEn_q  <= ldWordPc;
                    wbBaseEn_q  <= req_q.mode != AM_OFFSET;
                end
            end
            if (state_q == ST_MEM2 && memAck)
            begin
                done_q      <= 1'b1;
                wbTransEn_q <= req_q.op == OP_LDUAL;
                wbSecEn_q   <= req_q.op == OP_LDUAL;
                wbBaseEn_q  <= req_q.mode != AM_OFFSET;
                if (req_q.op == OP_LDUAL)
                    secData_q <= memRdata;
            end
        end
    end

    // =========================================================
    // Condition flags pass through untouched
    always_ff @(posedge clk)
    begin
        if (reset)
            appFlags_q <= `LSAU_RST_FLAGS;
        else
            appFlags_q <= appFlagsIn;
    end

    // =========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_flags_kept: assert property (
        appFlags_q == $past(appFlagsIn))
        else $error("flags were altered");
    a_flags_mem: assert property (
        wbTransEn_q |-> appFlags_q == $past(appFlagsIn))
        else $error("flags altered by a transfer");
    a_adr_result: assert property (
        accept && req.condPass && req.op == OP_ADR |=>
        wbTransEn_q && done_q && transData_q == $past(adrVal))
        else $error("address result wrong");
    a_pc_align: assert property (
        pcBase[1] == 1'b0 && pcBase[0] == req.pcVal[0]
        && pcBase[31:2] == req.pcVal[31:2] + 30'h0000_0001)
        else $error("pc base not word aligned");
    a_cond_quiet: assert property (
        accept && !req.condPass |=> done_q && !err_q && !wbTransEn_q
        && !wbBaseEn_q && !memValid_q)
        else $error("failed condition had effects");
    a_post_addr: assert property (
        accept && !noMem && req.mode == AM_POST |=>
        memValid_q && memAddr_q == $past(req.baseVal))
        else $error("post index address wrong");
    a_pre_wb: assert property (
        wbBaseEn_q && req_q.mode == AM_PRE |-> baseData_q == addr1_q)
        else $error("pre index writeback wrong");
    a_off_nowb: assert property (
        done_q && req_q.mode == AM_OFFSET |-> !wbBaseEn_q)
        else $error("offset mode wrote base");
    a_dual_step: assert property (
        state_q == ST_MEM2 && memValid_q |->
        memAddr_q == addr1_q + `LSAU_DUAL_STEP)
        else $error("second word address wrong");
    a_zero_ext: assert property (
        wbTransEn_q && req_q.op == OP_LOAD && req_q.size == SZ_BYTE
        && !req_q.sgn |-> transData_q[31:8] == 24'h000000)
        else $error("byte not zero extended");
    a_branch_lsb: assert property (
        branchEn_q |-> branchAddr_q[0] == 1'b0 && !wbTransEn_q)
        else $error("branch target bit 0 set");
    a_byte_strb: assert property (
        memValid_q && memWrite_q && req_q.size == SZ_BYTE
        && state_q == ST_MEM1 |-> $countones(memStrb_q) == 1)
        else $error("byte store strobes wrong");
    a_range_err: assert property (
        accept && req.condPass && illegal |=> err_q && !memValid_q)
        else $error("bad offset not refused");
    a_reg_shift: assert property (
        accept && !noMem && req.useReg |=>
        memAddr_q == $past(req.baseVal + (req.offVal << req.shift)))
        else $error("register offset address wrong");

    c_adr: cover property (accept && req.op == OP_ADR && req.condPass);
    c_ldual: cover property (state_q == ST_MEM2 && memAck
                             && req_q.op == OP_LDUAL);
    c_branch: cover property (branchEn_q);
    c_post_st: cover property (wbBaseEn_q && req_q.op == OP_STORE);

endmodule

`default_nettype wire

// [tb/lsau_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none

module lsau_mem_model
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Access request
    input  wire logic        memValid,
    input  wire logic        memWrite,
    input  wire logic [31:0] memAddr,
    input  wire logic [31:0] memWdata,
    input  wire logic [3:0]  memStrb,
    input  wire logic [3:0]  waitCycles,
    // Answer
    output var  logic        memAck,
    output var  logic [31:0] memRdata
);
    // =========================================================
    // Storage and wait counter
    logic [31:0] words [0:63];
    logic [3:0]  waitCnt;

    // =========================================================
    // Answer after waitCycles; data scrambled outside the ack
    always @(posedge clk)
    begin
        memAck   <= 1'b0;
        memRdata <= ~memRdata;
        if (reset)
        begin
            waitCnt  <= 4'h0;
            memRdata <= 32'hA5A5_5A5A;
        end
        else if (memValid && !memAck)
        begin
            if (waitCnt >= waitCycles)
            begin
                waitCnt  <= 4'h0;
                memAck   <= 1'b1;
                memRdata <= words[memAddr[7:2]];
                for (int b = 0; b < 4; b++)
                begin
                    if (memWrite && memStrb[b])
                        words[memAddr[7:2]][8*b +: 8] <= memWdata[8*b +: 8];
                end
            end
            else
                waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule

`default_nettype wire

// [tb/lsau_core_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module lsau_core_tb;
    import lsau_pkg::*;

    // =========================================================
    // Signals
    logic        clk;
    logic        reset;
    logic        reqValid;
    lsau_req_s   req;
    logic        reqReady_q;
    logic [3:0]  appFlagsIn;
    logic        memValid_q;
    logic        memWrite_q;
    logic [31:0] memAddr_q;
    logic [31:0] memWdata_q;
    logic [3:0]  memStrb_q;
    logic        memAck;
    logic [31:0] memRdata;
    logic        done_q;
    logic        err_q;
    logic        wbTransEn_q;
    logic [31:0] transData_q;
    logic        wbSecEn_q;
    logic [31:0] secData_q;
    logic        wbBaseEn_q;
    logic [31:0] baseData_q;
    logic        branchEn_q;
    logic [31:0] branchAddr_q;
    logic [3:0]  appFlags_q;
    logic [3:0]  memWait;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    int          accCount = 0;

    // =========================================================
    // Design and memory
    lsau_core dut
    (
        .clk(clk), .reset(reset), .reqValid(reqValid), .req(req),
        .reqReady_q(reqReady_q), .appFlagsIn(appFlagsIn),
        .memValid_q(memValid_q), .memWrite_q(memWrite_q),
        .memAddr_q(memAddr_q), .memWdata_q(memWdata_q),
        .memStrb_q(memStrb_q), .memAck(memAck), .memRdata(memRdata),
        .done_q(done_q), .err_q(err_q), .wbTransEn_q(wbTransEn_q),
        .transData_q(transData_q), .wbSecEn_q(wbSecEn_q),
        .secData_q(secData_q), .wbBaseEn_q(wbBaseEn_q),
        .baseData_q(baseData_q), .branchEn_q(branchEn_q),
        .branchAddr_q(branchAddr_q), .appFlags_q(appFlags_q)
    );

    lsau_mem_model mem
    (
        .clk(clk), .reset(reset), .memValid(memValid_q),
        .memWrite(memWrite_q), .memAddr(memAddr_q),
        .memWdata(memWdata_q), .memStrb(memStrb_q),
        .waitCycles(memWait), .memAck(memAck), .memRdata(memRdata)
    );

    // =========================================================
    // Clock, watchdog, access count
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (memValid_q && memAck)
            accCount <= accCount + 1;
        if (cycles == 3000)
        begin
            mismatches++;
            final_report();
        end
    end

    // =========================================================
    // Helpers
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%08h exp=%08h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    function automatic lsau_req_s mk(lsau_op_e op, lsau_size_e sz,
        lsau_mode_e md, logic [31:0] bv, logic [11:0] im, logic sb);
        lsau_req_s r;
        r = '0;
        r.op = op;
        r.size = sz;
        r.mode = md;
        r.baseVal = bv;
        r.imm = im;
        r.sub = sb;
        r.condPass = 1'b1;
        return r;
    endfunction

    task automatic run(input lsau_req_s r, input logic [3:0] fl);
        int n;
        n = 0;
        @(posedge clk);
        reqValid   <= 1'b1;
        req        <= r;
        appFlagsIn <= fl;
        @(posedge clk);
        reqValid <= 1'b0;
        #1;
        while (done_q !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk1(n < 40, 1'b1);
    endtask

    // =========================================================
    // Scenarios
    task automatic t_adr();
        lsau_req_s r;
        r = mk(OP_ADR, SZ_WORD, AM_OFFSET, 32'h0, 12'hFFF, 1'b0);
        r.pcVal = 32'h0000_1002;
        run(r, 4'h5);
        chk1(wbTransEn_q, 1'b1);
        chk32(transData_q, 32'h0000_2003);
        chk32({28'h0000000, appFlags_q}, 32'h0000_0005);
        r.sub = 1'b1;
        run(r, 4'hA);
        chk32(transData_q, 32'h0000_0005);
        $display("test adr done");
    endtask

    task automatic t_ext();
        lsau_req_s   r;
        lsau_size_e  szs [6] = '{SZ_BYTE, SZ_BYTE, SZ_BYTE, SZ_HALF,
                                 SZ_HALF, SZ_WORD};
        logic [11:0] offs [6] = '{12'h0, 12'h0, 12'h1, 12'h2, 12'h2, 12'h0};
        logic [31:0] expv [6] = '{32'h85, 32'hFFFF_FF85, 32'h7F,
                                  32'hFFFF_8001, 32'h8001, 32'h8001_7F85};
        logic [5:0]  sgns = 6'h0E;
        for (int i = 0; i < 6; i++)
        begin
            r = mk(OP_LOAD, szs[i], AM_OFFSET, 32'h40, offs[i], 1'b0);
            r.sgn = sgns[i];
            memWait <= 4'(i);
            run(r, 4'h9);
            chk32(transData_q, expv[i]);
            chk1(wbBaseEn_q, 1'b0);
            chk32({28'h0000000, appFlags_q}, 32'h0000_0009);
        end
        $display("test extend done");
    endtask

    task automatic t_index();
        run(mk(OP_LOAD, SZ_BYTE, AM_PRE, 32'h140, 12'hFF, 1'b1), 4'h0);
        chk32(memAddr_q, 32'h0000_0041);
        chk32(baseData_q, 32'h0000_0041);
        chk32(transData_q, 32'h0000_007F);
        run(mk(OP_LOAD, SZ_BYTE, AM_POST, 32'h40, 12'hFF, 1'b0), 4'h0);
        chk32(memAddr_q, 32'h0000_0040);
        chk1(wbBaseEn_q, 1'b1);
        chk32(baseData_q, 32'h0000_013F);
        run(mk(OP_LOAD, SZ_WORD, AM_OFFSET, 32'h41, 12'hFFF, 1'b0), 4'h0);
        chk1(err_q, 1'b0);
        chk32(transData_q, 32'h8001_7F85);
        $display("test index done");
    endtask

    task automatic t_refuse();
        lsau_req_s r;
        int        acc;
        for (int i = 0; i < 8; i++)
        begin
            case (i)
                0: r = mk(OP_LOAD, SZ_BYTE, AM_PRE, 32'h40, 12'h100, 1'b0);
                1: r = mk(OP_LOAD, SZ_WORD, AM_OFFSET, 32'h40, 12'h100, 1'b1);
                2: r = mk(OP_LDUAL, SZ_WORD, AM_OFFSET, 32'h40, 12'h400, 1'b0);
                3: r = mk(OP_SDUAL, SZ_WORD, AM_POST, 32'h40, 12'h3FE, 1'b0);
                4: r = mk(OP_STORE, SZ_BYTE, AM_OFFSET, 32'h40, 12'h0, 1'b0);
                5: r = mk(OP_LOAD, SZ_WORD, AM_PRE, 32'h40, 12'h0, 1'b0);
                6: r = mk(OP_LDUAL, SZ_WORD, AM_OFFSET, 32'h40, 12'h8, 1'b0);
                default: r = mk(OP_LOAD, SZ_WORD, AM_PRE, 32'h40, 12'h4, 1'b0);
            endcase
            r.sgn = (i == 4);
            r.useReg = (i == 5 || i == 6);
            r.condPass = (i != 7);
            acc = accCount;
            run(r, 4'h6);
            chk1(err_q, i != 7);
            chk1(wbTransEn_q | wbBaseEn_q, 1'b0);
            chk32(32'(accCount - acc), 32'h0);
        end
        $display("test refuse done");
    endtask

    task automatic t_regoff();
        lsau_req_s r;
        for (int s = 0; s < 4; s++)
        begin
            r = mk(OP_LOAD, SZ_WORD, AM_OFFSET, 32'h30, 12'h0, 1'b1);
            r.useReg = 1'b1;
            r.shift = 2'(s);
            r.offVal = 32'h10 >> s;
            r.size = (s == 3) ? SZ_BYTE : SZ_WORD;
            r.sgn = (s == 3);
            run(r, 4'h3);
            chk32(memAddr_q, 32'h0000_0040);
            chk32(transData_q, (s == 3) ? 32'hFFFF_FF85 : 32'h8001_7F85);
        end
        $display("test regoff done");
    endtask

    task automatic t_dual();
        lsau_req_s r;
        memWait <= 4'h2;
        run(mk(OP_LDUAL, SZ_WORD, AM_PRE, 32'h40, 12'h8, 1'b0), 4'h0);
        chk32(transData_q, 32'h1111_2222);
        chk1(wbSecEn_q, 1'b1);
        chk32(secData_q, 32'h3333_4444);
        chk32(baseData_q, 32'h0000_0048);
        r = mk(OP_SDUAL, SZ_WORD, AM_POST, 32'h400, 12'h3FC, 1'b1);
        r.store1 = 32'hAAAA_0001;
        r.store2 = 32'hBBBB_0002;
        run(r, 4'h0);
        chk32(mem.words[0], 32'hAAAA_0001);
        chk32(mem.words[1], 32'hBBBB_0002);
        chk32(baseData_q, 32'h0000_0004);
        $display("test dual done");
    endtask

    task automatic t_narrow();
        lsau_req_s r;
        r = mk(OP_STORE, SZ_BYTE, AM_OFFSET, 32'h51, 12'h0, 1'b0);
        r.store1 = 32'hAABB_CCDD;
        run(r, 4'h0);
        chk32(mem.words[20], 32'h1122_DD44);
        r = mk(OP_STORE, SZ_HALF, AM_OFFSET, 32'h52, 12'h0, 1'b0);
        r.store1 = 32'h1234_5566;
        run(r, 4'h0);
        chk32(mem.words[20], 32'h5566_DD44);
        $display("test narrow done");
    endtask

    task automatic t_pcload();
        lsau_req_s r;
        r = mk(OP_LOAD, SZ_WORD, AM_OFFSET, 32'h54, 12'h0, 1'b0);
        r.toPc = 1'b1;
        run(r, 4'h0);
        chk1(branchEn_q, 1'b1);
        chk32(branchAddr_q, 32'h0000_2000);
        chk1(wbTransEn_q, 1'b0);
        $display("test pcload done");
    endtask

    task automatic final_report();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // =========================================================
    // Main sequence
    initial
    begin
        reset = 1'b1;
        reqValid = 1'b0;
        req = '0;
        appFlagsIn = 4'h0;
        memWait = 4'h0;
        mem.words[16] = 32'h8001_7F85;
        mem.words[18] = 32'h1111_2222;
        mem.words[19] = 32'h3333_4444;
        mem.words[20] = 32'h1122_3344;
        mem.words[21] = 32'h0000_2001;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        t_adr();
        t_ext();
        t_index();
        t_refuse();
        t_regoff();
        t_dual();
        t_narrow();
        t_pcload();
        final_report();
    end
endmodule

`default_nettype wire
